/* File: hdl/dac_input_clocking_fifo.v */
// Input clocking and elastic input buffer of a dual-channel interpolating DAC.
// Assumes core_clk stands for the sample-rate clock and all pins are asynchronous.
// Summary of operation
// - Supply pin low and two-clock bit clear: run from sample-rate clock only.
// - External mode divides sample clock by interpolation field, drives rate clock out.
// - External mode: input latched on rate-clock rising edge, or falling edge when inverted.
// - Prescaler divides oscillator by 1,2,4,8; its output further divided 2,4,8,16.
// - Feedback field picks divided clock, which is also the input data rate.
// - In PLL mode the rate-clock pin shows PLL lock status.
// - Dual mode without buffer: data-rate clock sets divider phase.
// - Dual mode with buffer: data-rate clock only latches input.
// - Writing skip bit 1 bypasses the input buffer.
// - Buffer captures both ports and phase strobe on the selected data clock.
// - Buffer holds four samples with separate write and read pointers.
// - Initialisation forces pointers to start slots two entries apart.
// - Three-bit field selects the buffer initialisation trigger source.
// - Selected source is registered on write clock and rising-edge detected.
// - Pointers advance on their own clocks and may drift apart.
// - Interleaved mode multiplexes both ports onto channel A.
// - Clock mode decided by supply pin and two-clock bit together.
`timescale 1ns/10ps
`default_nettype none
`include "dac_clocking_regs.vh"

module dac_input_clocking_fifo #(
  parameter LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // Avalon-MM register slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Clock pins
  input  wire        pll_supply_select,
  input  wire        data_rate_clock_in,
  output reg         lock_or_rate_clock_out,
  // Data source pins
  input  wire [15:0] port_a_word,
  input  wire [15:0] port_b_word,
  input  wire        phase_strobe,
  input  wire        transmit_gate,
  input  wire        quad_marker,
  // Sample outputs toward the datapath
  output reg  [15:0] dac_a_word,
  output reg  [15:0] dac_b_word,
  output reg         phase_strobe_out,
  output reg         sample_valid
);

  // ------------------------------------------------------------------
  // Clock modes
  // ------------------------------------------------------------------
  localparam MODE_EXT  = 3'b001;
  localparam MODE_PLL  = 3'b010;
  localparam MODE_DUAL = 3'b100;
  localparam LOCK_W    = 16;
  localparam [LOCK_W-1:0] LOCK_MAX = LOCK_CYCLES[LOCK_W-1:0];

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  reg  [36:0] pin_meta_ff;
  reg  [36:0] pin_sync_ff;
  wire [36:0] pin_raw = {pll_supply_select, data_rate_clock_in, transmit_gate,
                         quad_marker, phase_strobe, port_b_word, port_a_word};

  // Two flip-flops before any logic reads a pin.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_ff <= 37'h0;
      pin_sync_ff <= 37'h0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire [15:0] a_sync     = pin_sync_ff[15:0];
  wire [15:0] b_sync     = pin_sync_ff[31:16];
  wire        strobe_s   = pin_sync_ff[32];
  wire        quad_s     = pin_sync_ff[33];
  wire        gate_s     = pin_sync_ff[34];
  wire        dclk_s     = pin_sync_ff[35];
  wire        pll_pin_s  = pin_sync_ff[36];

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  reg  [2:0]  first_cfg_ff;
  reg  [5:0]  second_cfg_ff;
  reg         fourth_cfg_ff;
  reg  [2:0]  sync_ctl_ff;
  reg         ack_ff;
  reg         sync_wr_ff;

  wire        bus_req  = avs_read | avs_write;
  wire        wr_go    = avs_write & ack_ff;
  wire        skip     = first_cfg_ff[`SKIP_BIT];
  wire [1:0]  interp   = first_cfg_ff[`INTERP_LSB+1:`INTERP_LSB];
  wire        two_clk  = second_cfg_ff[`TWO_CLK_BIT];
  wire        edge_inv = second_cfg_ff[`EDGE_INV_BIT];
  wire [1:0]  presc    = second_cfg_ff[`PRESC_LSB+1:`PRESC_LSB];
  wire [1:0]  fb_sel   = second_cfg_ff[`FEEDBACK_LSB+1:`FEEDBACK_LSB];
  wire        interlv  = fourth_cfg_ff;
  wire [2:0]  sync_src = sync_ctl_ff;

  // One wait cycle per access; the answer stands at the second edge.
  assign avs_waitrequest = bus_req & ~ack_ff;

  // Acknowledge toggles so each access takes exactly two cycles.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req & ~ack_ff;
  end

  // Register writes take effect at the edge where waitrequest is low.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      first_cfg_ff  <= `FIRST_CONFIG_RST;
      second_cfg_ff <= `SECOND_CONFIG_RST;
      fourth_cfg_ff <= `FOURTH_CONFIG_RST;
      sync_ctl_ff   <= `SYNC_CONTROL_RST;
    end else if (wr_go) begin
      case (avs_address)
        `FIRST_CONFIG_OFS:  first_cfg_ff  <= avs_writedata[2:0];
        `SECOND_CONFIG_OFS: second_cfg_ff <= avs_writedata[5:0];
        `FOURTH_CONFIG_OFS: fourth_cfg_ff <= avs_writedata[`INTERLEAVE_BIT];
        `SYNC_CONTROL_OFS:  sync_ctl_ff   <= avs_writedata[2:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Clock mode decode
  // ------------------------------------------------------------------
  reg  [2:0] mode;

  // Supply pin high wins over the two-clock bit.
  always @* begin
    if (pll_pin_s)
      mode = MODE_PLL;
    else if (two_clk)
      mode = MODE_DUAL;
    else
      mode = MODE_EXT;
  end

  // Buffer use: dual mode also needs the edge-invert bit set.
  wire use_buffer = ~skip & ((mode != MODE_DUAL) | edge_inv);

  // ------------------------------------------------------------------
  // Internal divider and rate clock
  // ------------------------------------------------------------------
  reg  [6:0] div_cnt_ff;
  reg  [2:0] shift;
  reg        rate_clk_ff;
  reg        dclk_q_ff;
  wire       dclk_rise = dclk_s & ~dclk_q_ff;
  wire       phase_set = (mode == MODE_DUAL) & ~use_buffer & dclk_rise;

  // Divide ratio: interpolation field, or prescaler times feedback in PLL mode.
  always @* begin
    case (mode)
      MODE_PLL:  shift = {1'b0, presc} + {1'b0, fb_sel};
      MODE_EXT:  shift = {1'b0, interp};
      MODE_DUAL: shift = {1'b0, interp};
      default:   shift = 3'h0;
    endcase
  end

  wire nxt_rate_clk = div_cnt_ff[shift];

  // Divider runs freely; the data-rate clock may re-phase it.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_ff  <= 7'h00;
      rate_clk_ff <= 1'b0;
      dclk_q_ff   <= 1'b0;
    end else begin
      dclk_q_ff   <= dclk_s;
      rate_clk_ff <= nxt_rate_clk;
      if (phase_set)
        div_cnt_ff <= 7'h01 << shift;
      else
        div_cnt_ff <= div_cnt_ff + 7'h01;
    end
  end

  // One tick per input sample on the rising edge of the rate clock.
  wire rd_tick = nxt_rate_clk & ~rate_clk_ff;

  // ------------------------------------------------------------------
  // PLL lock indication
  // ------------------------------------------------------------------
  reg [LOCK_W-1:0] lock_cnt_ff;
  wire             locked = (lock_cnt_ff == LOCK_MAX);

  // Lock is declared a fixed time after entering PLL mode.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      lock_cnt_ff <= {LOCK_W{1'b0}};
    else if (mode != MODE_PLL)
      lock_cnt_ff <= {LOCK_W{1'b0}};
    else if (!locked)
      lock_cnt_ff <= lock_cnt_ff + {{(LOCK_W-1){1'b0}}, 1'b1};
  end

  // Pin shows lock in PLL mode, the divided rate clock otherwise.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      lock_or_rate_clock_out <= 1'b0;
    else if (mode == MODE_PLL)
      lock_or_rate_clock_out <= locked;
    else
      lock_or_rate_clock_out <= rate_clk_ff;
  end

  // ------------------------------------------------------------------
  // Write clock selection
  // ------------------------------------------------------------------
  reg  pin_q_ff;
  wire pin_rise = lock_or_rate_clock_out & ~pin_q_ff;
  wire pin_fall = ~lock_or_rate_clock_out & pin_q_ff;
  reg  wr_stb;

  // The rate clock is sensed back at the output pin.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      pin_q_ff <= 1'b0;
    else
      pin_q_ff <= lock_or_rate_clock_out;
  end

  // External mode latches on the pin edge; other modes on the data clock.
  always @* begin
    case (mode)
      MODE_EXT:  wr_stb = edge_inv ? pin_fall : pin_rise;
      MODE_DUAL: wr_stb = dclk_rise;
      MODE_PLL:  wr_stb = dclk_rise;
      default:   wr_stb = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Synchronisation source
  // ------------------------------------------------------------------
  reg  src_q_ff;
  reg  a15_q_ff;
  reg  once_armed_ff;
  reg  sel_src;
  wire a15_edge = wr_stb & (a_sync[15] ^ a15_q_ff);
  wire write_now = (sync_src == `SYNC_WRITE_NOW) | (sync_src == `SYNC_WRITE_NOW_ALT);

  // Pick the selected trigger level.
  always @* begin
    case (sync_src)
      `SYNC_TX_GATE:      sel_src = gate_s;
      `SYNC_PHASE_STROBE: sel_src = strobe_s;
      `SYNC_QUAD_MARKER:  sel_src = quad_s;
      `SYNC_PORT_B_MSB:   sel_src = b_sync[15];
      `SYNC_PORT_A_ONCE:  sel_src = once_armed_ff & a15_edge;
      default:            sel_src = sync_wr_ff & write_now;
    endcase
  end

  // Rising edge of the source, registered on the write clock.
  wire init_stb = wr_stb & sel_src & ~src_q_ff & (sync_src != `SYNC_DISABLED);

  // Source history and the one-shot arming advance on the write clock.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_q_ff      <= 1'b0;
      a15_q_ff      <= 1'b0;
      once_armed_ff <= 1'b1;
      sync_wr_ff    <= 1'b0;
    end else begin
      if (wr_stb) begin
        src_q_ff <= sel_src;
        a15_q_ff <= a_sync[15];
      end
      // A sync-control write sets the pending pulse; the set wins.
      if (wr_go && avs_address == `SYNC_CONTROL_OFS)
        sync_wr_ff <= 1'b1;
      else if (wr_stb)
        sync_wr_ff <= 1'b0;
      // The port-A trigger fires once, then re-arms on a sync-control write.
      if (wr_go && avs_address == `SYNC_CONTROL_OFS)
        once_armed_ff <= 1'b1;
      else if (sync_src == `SYNC_PORT_A_ONCE && init_stb)
        once_armed_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Elastic buffer and bypass path
  // ------------------------------------------------------------------
  wire [32:0] buf_out;
  wire [1:0]  wr_ptr;
  wire [1:0]  rd_ptr;

  elastic_buffer #(
    .WIDTH (33),
    .DEPTH (4)
  ) u_buffer (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .wr_stb     (wr_stb),
    .wr_data    ({strobe_s, b_sync, a_sync}),
    .init_stb   (init_stb),
    .rd_stb     (rd_tick),
    .rd_data_ff (buf_out),
    .wr_ptr     (wr_ptr),
    .rd_ptr     (rd_ptr)
  );

  reg         sample_q_ff;
  reg         half_ff;
  wire [32:0] src_word = use_buffer ? buf_out : {strobe_s, b_sync, a_sync};

  // Output words follow the read tick; buffer output lags by one cycle.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sample_q_ff      <= 1'b0;
      half_ff          <= 1'b0;
      dac_a_word       <= 16'h0000;
      dac_b_word       <= 16'h0000;
      phase_strobe_out <= 1'b0;
      sample_valid     <= 1'b0;
    end else begin
      sample_q_ff  <= rd_tick;
      sample_valid <= sample_q_ff;
      if (sample_q_ff) begin
        phase_strobe_out <= src_word[32];
        dac_b_word       <= src_word[31:16];
        half_ff          <= ~half_ff;
        if (interlv)
          dac_a_word <= half_ff ? src_word[31:16] : src_word[15:0];
        else
          dac_a_word <= src_word[15:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Register read-back
  // ------------------------------------------------------------------
  // Read data is loaded in the wait cycle and stands at the answer edge.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_ff) begin
      case (avs_address)
        `FIRST_CONFIG_OFS:  avs_readdata <= {29'h0, first_cfg_ff};
        `SECOND_CONFIG_OFS: avs_readdata <= {26'h0, second_cfg_ff};
        `FOURTH_CONFIG_OFS: avs_readdata <= {31'h0, fourth_cfg_ff};
        `SYNC_CONTROL_OFS:  avs_readdata <= {29'h0, sync_ctl_ff};
        `STATUS_OFS:        avs_readdata <= {23'h0, use_buffer, rd_ptr, wr_ptr,
                                             locked, mode};
        default:            avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule // dac_input_clocking_fifo
`default_nettype wire

/* File: hdl/dac_clocking_regs.vh */
// Register map, field positions, reset values and timing counts of the
// input clocking block with its elastic input buffer.
// Assumes byte addressing on a 32-bit Avalon-MM register bus.
`ifndef DAC_CLOCKING_REGS_VH
`define DAC_CLOCKING_REGS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define FIRST_CONFIG_OFS   5'h00
`define SECOND_CONFIG_OFS  5'h04
`define FOURTH_CONFIG_OFS  5'h0c
`define SYNC_CONTROL_OFS   5'h10
`define STATUS_OFS         5'h14

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define SKIP_BIT           0
`define INTERP_LSB         1
`define TWO_CLK_BIT        0
`define EDGE_INV_BIT       1
`define PRESC_LSB          2
`define FEEDBACK_LSB       4
`define INTERLEAVE_BIT     0
`define SYNC_SRC_LSB       0

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define FIRST_CONFIG_RST   3'h0
`define SECOND_CONFIG_RST  6'h00
`define FOURTH_CONFIG_RST  1'h0
`define SYNC_CONTROL_RST   3'h6

// ------------------------------------------------------------------
// Buffer pointer start slots, two entries apart
// ------------------------------------------------------------------
`define WRITE_SLOT_INITIAL 2'h2
`define READ_SLOT_INITIAL  2'h0

// ------------------------------------------------------------------
// Synchronisation source codes
// ------------------------------------------------------------------
`define SYNC_TX_GATE       3'h0
`define SYNC_PHASE_STROBE  3'h1
`define SYNC_QUAD_MARKER   3'h2
`define SYNC_PORT_B_MSB    3'h3
`define SYNC_PORT_A_ONCE   3'h4
`define SYNC_WRITE_NOW     3'h5
`define SYNC_DISABLED      3'h6
`define SYNC_WRITE_NOW_ALT 3'h7

// ------------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------------
`define PLL_LOCK_CYCLES    200

`endif

/* File: hdl/elastic_buffer.v */
// Four-entry elastic buffer with independent write and read pointers.
// Assumes write and read strobes are single-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
`include "dac_clocking_regs.vh"

module elastic_buffer #(
  parameter WIDTH = 33,
  parameter DEPTH = 4
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // Write side
  input  wire             wr_stb,
  input  wire [WIDTH-1:0] wr_data,
  // Pointer initialisation
  input  wire             init_stb,
  // Read side
  input  wire             rd_stb,
  output reg  [WIDTH-1:0] rd_data_ff,
  output wire [1:0]       wr_ptr,
  output wire [1:0]       rd_ptr
);

  // ------------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------------
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // Four sample slots.
  reg [1:0]       wr_ptr_ff;
  reg [1:0]       rd_ptr_ff;

  assign wr_ptr = wr_ptr_ff;
  assign rd_ptr = rd_ptr_ff;

  // Pointers start two apart at reset and at every initialisation.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_ff <= `WRITE_SLOT_INITIAL;
      rd_ptr_ff <= `READ_SLOT_INITIAL;
    end else if (init_stb) begin
      wr_ptr_ff <= `WRITE_SLOT_INITIAL;
      rd_ptr_ff <= `READ_SLOT_INITIAL;
    end else begin
      // Free-running pointers; drift may let one overrun the other.
      if (wr_stb)
        wr_ptr_ff <= wr_ptr_ff + 2'h1;
      if (rd_stb)
        rd_ptr_ff <= rd_ptr_ff + 2'h1;
    end
  end

  // Each slot is written when the write pointer points at it.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_slot
      localparam [31:0] SLOT = gi;
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn)
          mem_ff[gi] <= {WIDTH{1'b0}};
        else if (wr_stb && {30'h0, wr_ptr_ff} == SLOT)
          mem_ff[gi] <= wr_data;
      end
    end
  endgenerate

  // Read word is registered on each read strobe.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      rd_data_ff <= {WIDTH{1'b0}};
    else if (rd_stb)
      rd_data_ff <= mem_ff[rd_ptr_ff];
  end

endmodule // elastic_buffer
`default_nettype wire

/* File: testbench/dac_input_clocking_fifo_checker.sv */
// Checker on the top ports of the input clocking block and its elastic buffer.
// Assumes the bench keeps the lock count short and drives one clock domain.
`timescale 1ns/10ps
`default_nettype none
module dac_input_clocking_fifo_checker #(
  parameter LOCK_CYCLES = 200
) (
  // Clock, reset and bus handshake
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // Clock pins and sample outputs
  input wire logic        pll_supply_select,
  input wire logic        lock_or_rate_clock_out,
  input wire logic [15:0] dac_a_word,
  input wire logic [15:0] dac_b_word,
  input wire logic        phase_strobe_out,
  input wire logic        sample_valid
);
  localparam int LOCK_HI = LOCK_CYCLES + 8;
  wire req = avs_read | avs_write;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Entry into PLL mode, then a low lock level that must rise in time.
  sequence pll_fresh;
    $rose(pll_supply_select);
  endsequence
  sequence lock_wait;
    ##5 !lock_or_rate_clock_out ##[1:LOCK_HI] lock_or_rate_clock_out;
  endsequence
  // Bus handshake: exactly one wait state, none while idle.
  wait_start_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("new request without a wait state");
  wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest)
    else $error("wait state while idle");
  // Sample words change only with their one-cycle valid pulse.
  valid_pulse_a: assert property (sample_valid |=> !sample_valid)
    else $error("valid pulse longer than one cycle");
  words_hold_a: assert property (!sample_valid |-> $stable(dac_a_word) && $stable(dac_b_word))
    else $error("sample words changed without valid");
  strobe_hold_a: assert property ($changed(phase_strobe_out) |-> sample_valid)
    else $error("strobe changed without valid");
  // Lock status in PLL mode and rate clock outside it.
  lock_rise_a: assert property (pll_fresh |-> lock_wait)
    else $error("lock level wrong after entering PLL mode");
  lock_hold_a: assert property (pll_supply_select [*8] ##0 lock_or_rate_clock_out
    |=> lock_or_rate_clock_out)
    else $error("lock level dropped");
  rate_toggle_a: assert property ((!pll_supply_select) [*6]
    |-> ##[1:9] $changed(lock_or_rate_clock_out))
    else $error("rate clock stalled");
endmodule // dac_input_clocking_fifo_checker
bind dac_input_clocking_fifo dac_input_clocking_fifo_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (
  .core_clk, .rstn, .avs_read, .avs_write, .avs_waitrequest, .pll_supply_select,
  .lock_or_rate_clock_out, .dac_a_word, .dac_b_word, .phase_strobe_out, .sample_valid);
`default_nettype wire

/* File: testbench/data_source_model.sv */
// Data source model: counts samples and drives both ports and the strobe.
// Assumes the bench selects dual use, latch edge, hold and the flag.
`timescale 1ns/10ps
`default_nettype none
module data_source_model (
  // Clocks and controls
  input  wire logic        core_clk,
  input  wire logic        rate_clk,
  input  wire logic        dual,
  input  wire logic        inv,
  input  wire logic        hold,
  input  wire logic        flag,
  // Pins toward the block
  output wire logic        data_clk,
  output wire logic [15:0] port_a,
  output wire logic [15:0] port_b,
  output wire logic        strobe
);
  logic [1:0]  div_ff = 2'h0;
  logic [14:0] cnt_ff = 15'h0;
  logic        prev_ff = 1'b0;
  wire         src = dual ? data_clk : rate_clk;
  // Own data clock runs in dual and PLL use and stands still on hold.
  assign data_clk = dual & div_ff[1];
  // Bit 15 of both ports carries the flag so it can serve as a trigger.
  assign port_a = {flag, cnt_ff};
  assign port_b = {flag, ~cnt_ff};
  assign strobe = flag;
  // New word on the edge opposite to the latch edge, so setup is never marginal.
  always @(posedge core_clk) begin
    if (dual && !hold) div_ff <= div_ff + 2'h1;
    prev_ff <= src;
    if (prev_ff != src && src == (inv & !dual)) cnt_ff <= cnt_ff + 15'h1;
  end
endmodule // data_source_model
`default_nettype wire

/* File: testbench/dac_input_clocking_fifo_tb.sv */
// Self-checking bench for the input clocking block and its elastic buffer.
// Assumes the checker is bound and the data source model drives the ports.
`timescale 1ns/10ps
`default_nettype none
`include "dac_clocking_regs.vh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dac_input_clocking_fifo_tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        pll_supply_select = 1'b0;
  logic        transmit_gate = 1'b0;
  logic        quad_marker = 1'b0;
  logic        dual_m = 1'b0, inv_m = 1'b0, hold_m = 1'b0, flag_m = 1'b0;
  logic [31:0] avs_readdata;
  logic [15:0] port_a_word, port_b_word, dac_a_word, dac_b_word;
  logic        avs_waitrequest, lock_or_rate_clock_out, data_rate_clock_in;
  logic        phase_strobe, phase_strobe_out, sample_valid;
  int          n_fail = 0;
  int          n_tests = 0;
  localparam logic [31:0] rst_val [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h6};
  localparam logic [4:0]  ofs [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
  localparam logic [2:0]  c1 [6] = '{3'h2, 3'h3, 3'h2, 3'h2, 3'h2, 3'h2};
  localparam logic [5:0]  c2 [6] = '{6'h0, 6'h0, 6'h2, 6'h1, 6'h0, 6'h3};
  localparam logic        c4 [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam logic        dm [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h7, 3'h6};

  always #25 core_clk = ~core_clk;

  dac_input_clocking_fifo #(.LOCK_CYCLES(8)) dut_u (.core_clk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pll_supply_select,
    .data_rate_clock_in, .lock_or_rate_clock_out, .port_a_word, .port_b_word, .phase_strobe,
    .transmit_gate, .quad_marker, .dac_a_word, .dac_b_word, .phase_strobe_out, .sample_valid);
  data_source_model src_u (.core_clk, .rate_clk(lock_or_rate_clock_out), .dual(dual_m),
    .inv(inv_m), .hold(hold_m), .flag(flag_m), .data_clk(data_rate_clock_in),
    .port_a(port_a_word), .port_b(port_b_word), .strobe(phase_strobe));

  // One bus transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Cycles between two rate clock rises or two valid pulses.
  task automatic gap(input bit pin, output int g);
    time t0;
    repeat (2) @(posedge core_clk iff sample_valid === 1'b1);
    if (pin) @(posedge lock_or_rate_clock_out);
    t0 = $time;
    if (pin) @(posedge lock_or_rate_clock_out);
    else @(posedge core_clk iff sample_valid === 1'b1);
    g = int'(($time - t0) / 50);
  endtask

  // Pointer separation read at a fixed phase after a valid pulse.
  task automatic ptr_gap(output logic [1:0] d);
    logic [31:0] q;
    @(posedge core_clk iff sample_valid === 1'b1);
    bus(1'b0, `STATUS_OFS, 32'h0, q);
    d = q[5:4] - q[7:6];
  endtask

  // Checks a run of samples for counting order and port pairing.
  task automatic stream(input logic il);
    logic [14:0] last;
    int k;
    for (k = 0; k < 14; k++) begin
      @(posedge core_clk iff sample_valid === 1'b1);
      if (k > 8 && il) `CHK((dac_a_word[14:0] + last) inside {15'h0, 15'h7ffe}, 1'b1)
      else if (k > 8) `CHK(dac_a_word[14:0], last + 15'h1)
      if (k > 8 && !il) `CHK(dac_b_word[14:0], ~dac_a_word[14:0])
      last = dac_a_word[14:0];
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    logic [31:0] q;
    logic [1:0]  d0, d;
    int          g, i;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    // Pointers are read before the first rate tick moves them.
    bus(1'b0, `STATUS_OFS, 32'h0, q);
    `CHK({q[8], q[2:0]}, 4'h9)
    `CHK(q[5:4] - q[7:6], 2'h2)
    for (i = 0; i < 5; i++) begin
      bus(1'b0, ofs[i], 32'h0, q);
      `CHK(q, rst_val[i])
    end
    wr(5'h08, 32'hffff);
    bus(1'b0, 5'h08, 32'h0, q);
    `CHK(q, 32'h0)
    for (i = 0; i < 4; i++) begin
      wr(`FIRST_CONFIG_OFS, i << 1);
      gap(1'b1, g);
      `CHK(g, 2 << i)
    end
    for (i = 0; i < 6; i++) begin
      dual_m <= dm[i];
      inv_m <= c2[i][1] & !dm[i];
      wr(`FIRST_CONFIG_OFS, c1[i]);
      wr(`SECOND_CONFIG_OFS, c2[i]);
      wr(`FOURTH_CONFIG_OFS, c4[i]);
      repeat (80) @(posedge core_clk);
      bus(1'b0, `STATUS_OFS, 32'h0, q);
      `CHK(q[2:0], dm[i] ? 3'h4 : 3'h1)
      `CHK(q[8], !c1[i][0] && (!dm[i] || c2[i][1]))
      stream(c4[i]);
    end
    wr(`SYNC_CONTROL_OFS, 32'h5);
    repeat (20) @(posedge core_clk);
    ptr_gap(d0);
    for (i = 0; i < 8; i++) begin
      hold_m <= 1'b1;
      repeat (8) @(posedge core_clk);
      hold_m <= 1'b0;
      if (i != 5) wr(`SYNC_CONTROL_OFS, {29'h0, codes[i]});
      {transmit_gate, quad_marker, flag_m} <= 3'h7;
      repeat (12) @(posedge core_clk);
      {transmit_gate, quad_marker, flag_m} <= 3'h0;
      repeat (20) @(posedge core_clk);
      ptr_gap(d);
      `CHK(d, (i == 5 || i == 7) ? d0 - 2'h2 : d0)
    end
    wr(`FIRST_CONFIG_OFS, 32'h1);
    pll_supply_select <= 1'b1;
    repeat (60) @(posedge core_clk);
    `CHK(lock_or_rate_clock_out, 1'b1)
    for (i = 0; i < 3; i++) begin
      wr(`SECOND_CONFIG_OFS, {26'h0, 2'(i + 1), 2'(i), 2'h1});
      gap(1'b0, g);
      `CHK(g, 2 << (2 * i + 1))
    end
    bus(1'b0, `STATUS_OFS, 32'h0, q);
    `CHK(q[3:0], 4'ha)
    report_and_stop();
  end

  // Watchdog that ends a hung run.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end
endmodule // dac_input_clocking_fifo_tb
`default_nettype wire
